// [rtl/cmd_cond_defs.svh]
`ifndef CMD_COND_DEFS_SVH
`define CMD_COND_DEFS_SVH
`define ADDR_CTRL      8'h00
`define ADDR_THRESH    8'h04
`define ADDR_GAIN      8'h08
`define ADDR_OFFSET    8'h0c
`define ADDR_RAMP_ALL  8'h10
`define ADDR_RAMP_PU   8'h14
`define ADDR_RAMP_PD   8'h18
`define ADDR_RAMP_NU   8'h1c
`define ADDR_RAMP_ND   8'h20
`define ADDR_LIN_BASE  8'h40
`define ADDR_STATUS    8'h80
`define ADDR_OUTPUT    8'h84
`define CTRL_TYPE_LSB  0
`define CTRL_POL_BIT   4
`define CTRL_LINEN_BIT 5
`define CTRL_RESET     32'h0000_0000
`define GAIN_RESET     16'h0100
`define RAMP_RESET     16'h0000
`define FULL_SCALE     16'sh7fff
`define LIN_POINTS     9
`define SAMPLE_NS      40000
`define CLK_NS         40
`define SAMPLE_CYC     (`SAMPLE_NS / `CLK_NS)
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// [rtl/cmd_cond_pkg.sv]
package cmd_cond_pkg;
   typedef enum logic [2:0] {
      SIG_PM10V, SIG_0_10V, SIG_0_20MA, SIG_4_20MA, SIG_PM10MA, SIG_12PM8MA
   } sig_type_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wr_req_t;
   typedef struct packed {
      logic        coil_a;
      logic        coil_b;
      logic [15:0] demand;
   } coil_out_t;
endpackage : cmd_cond_pkg

// [rtl/command_signal_conditioning.sv]
`timescale 1ns/1ps
`include "cmd_cond_defs.svh"
// How it works
// RQ1: Signal type selects range; raw code maps to signed command, type-scaled.
// RQ2: Configuring party picks unipolar or bipolar per valve; advice only.
// RQ3: Positive polarity: positive command energizes coil A, negative coil B.
// RQ4: Negative polarity inverts command sign, swapping the energized coil.
// RQ5: Threshold is percent of full scale of the selected signal type.
// RQ6: Magnitude below threshold gives zero out of the threshold stage.
// RQ7: Magnitude above threshold passes the command unchanged.
// RQ8: Gain in 8.8 fixed point scales the command toward coil demand.
// RQ9: Offset adds a fixed step outward for nonzero commands of either sign.
// RQ10: Piecewise linear curve maps command; non-monotonic table is refused.
// RQ11: Ramp moves the output linearly in time toward the target.
// RQ12: Ramp time is for a full-scale step; slope is constant.
// RQ13: One write sets all ramps; separate rise and fall times also settable.
// RQ14: Positive-range ramps belong to one coil, negative to other by polarity.
// RQ15: Each direction has its own upward and downward ramp setting.
// RQ16: Stages run per sample in fixed order; result saturates to full scale.
module command_signal_conditioning
   import cmd_cond_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // Command input sample, raw unsigned converter code, same clock domain.
   input  wire logic [15:0] cmd_raw_in,
   // AXI4-Lite slave.
   input  wire logic [7:0]  s_awaddr_in,
   input  wire logic        s_awvalid_in,
   output logic             s_awready_out,
   input  wire logic [31:0] s_wdata_in,
   input  wire logic [3:0]  s_wstrb_in,
   input  wire logic        s_wvalid_in,
   output logic             s_wready_out,
   output logic [1:0]       s_bresp_out,
   output logic             s_bvalid_out,
   input  wire logic        s_bready_in,
   input  wire logic [7:0]  s_araddr_in,
   input  wire logic        s_arvalid_in,
   output logic             s_arready_out,
   output logic [31:0]      s_rdata_out,
   output logic [1:0]       s_rresp_out,
   output logic             s_rvalid_out,
   input  wire logic        s_rready_in,
   // Coil demand.
   output coil_out_t        coil_out,
   output logic             sample_out
);
   localparam int NL = `LIN_POINTS;
   logic [31:0]        ctrl_ff;
   logic [7:0]         thresh_ff;
   logic [15:0]        gain_ff;
   logic [15:0]        offset_ff;
   logic [15:0]        ramp_ff [4];
   logic signed [15:0] lin_ff [NL];
   logic               lin_bad_ff;
   logic               aw_got_ff, w_got_ff;
   logic [7:0]         aw_ff;
   logic [31:0]        wd_ff;
   logic [3:0]         ws_ff;
   logic [9:0]         tick_ff;
   logic               tick;
   logic signed [15:0] cmd_ff, out_ff;
   logic [31:0]        acc_ff;
   wr_req_t            wreq;
   sig_type_t          stype;

   assign stype = sig_type_t'(ctrl_ff[`CTRL_TYPE_LSB +: 3]);
   assign wreq = '{addr: aw_ff, data: wd_ff, strb: ws_ff};

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   function automatic logic signed [15:0] sat(input logic signed [31:0] v);
      if (v > 32'sd32767) sat = `FULL_SCALE;
      else if (v < -32'sd32767) sat = -`FULL_SCALE;
      else sat = v[15:0];
   endfunction : sat

   // Raw code to signed command within the selected range.
   function automatic logic signed [15:0] to_cmd(input logic [15:0] r,
                                                 input sig_type_t t);
      logic signed [31:0] v;
      v = 32'sd0;
      case (t)
         SIG_0_10V, SIG_0_20MA: v = {17'h0, r[15:1]};
         SIG_4_20MA: v = ($signed({16'h0, r}) - 32'sd13107) * 32'sd5 / 32'sd8;
         default: v = {16'h0, r} - 32'sd32768;
      endcase
      to_cmd = sat(v);
   endfunction : to_cmd

   wire w_fire = aw_got_ff & w_got_ff & ~s_bvalid_out;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         aw_ff     <= 8'h00;
         wd_ff     <= 32'h0000_0000;
         ws_ff     <= 4'h0;
      end else begin
         if (s_awvalid_in && s_awready_out) begin
            aw_got_ff <= 1'b1;
            aw_ff     <= s_awaddr_in;
         end else if (w_fire) begin
            aw_got_ff <= 1'b0;
         end
         if (s_wvalid_in && s_wready_out) begin
            w_got_ff <= 1'b1;
            wd_ff    <= s_wdata_in;
            ws_ff    <= s_wstrb_in;
         end else if (w_fire) begin
            w_got_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         s_awready_out <= 1'b0;
         s_wready_out  <= 1'b0;
      end else begin
         s_awready_out <= ~aw_got_ff & ~(s_awvalid_in & s_awready_out);
         s_wready_out  <= ~w_got_ff & ~(s_wvalid_in & s_wready_out);
      end
   end

   wire wr_lin = wreq.addr >= `ADDR_LIN_BASE &&
                 wreq.addr < `ADDR_LIN_BASE + 8'(4 * NL);
   wire [3:0] lin_idx = 4'((wreq.addr - `ADDR_LIN_BASE) >> 2);
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl_ff   <= `CTRL_RESET;
         thresh_ff <= 8'h00;
         gain_ff   <= `GAIN_RESET;
         offset_ff <= 16'h0000;
         for (int i = 0; i < 4; i++) ramp_ff[i] <= `RAMP_RESET;
         s_bvalid_out <= 1'b0;
         s_bresp_out  <= `RESP_OKAY;
      end else begin
         if (s_bvalid_out && s_bready_in) s_bvalid_out <= 1'b0;
         if (w_fire) begin
            s_bvalid_out <= 1'b1;
            s_bresp_out  <= `RESP_OKAY;
            case (wreq.addr)
               `ADDR_CTRL: if (wreq.strb[0]) ctrl_ff[7:0] <= wreq.data[7:0];
               `ADDR_THRESH: if (wreq.strb[0]) begin // see RQ5
                  thresh_ff <= wreq.data[7:0] > 8'd100 ? 8'd100
                                                      : wreq.data[7:0];
               end
               `ADDR_GAIN: gain_ff <= merge(gain_ff, wreq.data, wreq.strb);
               `ADDR_OFFSET: offset_ff <= merge(offset_ff, wreq.data,
                                                wreq.strb);
               `ADDR_RAMP_ALL: begin // see RQ13
                  for (int i = 0; i < 4; i++) begin
                     ramp_ff[i] <= merge(ramp_ff[i], wreq.data, wreq.strb);
                  end
               end
               `ADDR_RAMP_PU: ramp_ff[0] <= merge(ramp_ff[0], wreq.data,
                                                  wreq.strb); // see RQ15
               `ADDR_RAMP_PD: ramp_ff[1] <= merge(ramp_ff[1], wreq.data,
                                                  wreq.strb);
               `ADDR_RAMP_NU: ramp_ff[2] <= merge(ramp_ff[2], wreq.data,
                                                  wreq.strb);
               `ADDR_RAMP_ND: ramp_ff[3] <= merge(ramp_ff[3], wreq.data,
                                                  wreq.strb);
               default: if (!wr_lin) s_bresp_out <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // Curve points span -full scale to +full scale in equal steps.
   // A curve that falls anywhere is flagged one cycle after the write that makes it fall, then bypassed.
   generate
      for (genvar g = 0; g < NL; g++) begin : g_lin
         localparam logic signed [15:0] DEF =
            16'(-32767 + (g * 65534) / (NL - 1));
         always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) lin_ff[g] <= DEF;
            else if (w_fire && wr_lin && lin_idx == 4'(g) &&
                     &wreq.strb[1:0]) lin_ff[g] <= wreq.data[15:0];
         end
      end
   endgenerate
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) lin_bad_ff <= 1'b0;
      else begin
         lin_bad_ff <= 1'b0;
         for (int i = 1; i < NL; i++) begin
            if (lin_ff[i] < lin_ff[i-1]) lin_bad_ff <= 1'b1; // see RQ10
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         s_arready_out <= 1'b0;
         s_rvalid_out  <= 1'b0;
         s_rdata_out   <= 32'h0000_0000;
         s_rresp_out   <= `RESP_OKAY;
      end else begin
         s_arready_out <= ~s_rvalid_out & ~(s_arvalid_in & s_arready_out);
         if (s_rvalid_out && s_rready_in) s_rvalid_out <= 1'b0;
         if (s_arvalid_in && s_arready_out) begin
            s_rvalid_out <= 1'b1;
            s_rresp_out  <= `RESP_OKAY;
            s_rdata_out  <= 32'h0000_0000;
            case (s_araddr_in)
               `ADDR_CTRL:    s_rdata_out <= {24'h0, ctrl_ff[7:0]};
               `ADDR_THRESH:  s_rdata_out <= {24'h0, thresh_ff};
               `ADDR_GAIN:    s_rdata_out <= {16'h0, gain_ff};
               `ADDR_OFFSET:  s_rdata_out <= {16'h0, offset_ff};
               `ADDR_RAMP_PU: s_rdata_out <= {16'h0, ramp_ff[0]};
               `ADDR_RAMP_PD: s_rdata_out <= {16'h0, ramp_ff[1]};
               `ADDR_RAMP_NU: s_rdata_out <= {16'h0, ramp_ff[2]};
               `ADDR_RAMP_ND: s_rdata_out <= {16'h0, ramp_ff[3]};
               `ADDR_STATUS:  s_rdata_out <= {30'h0, lin_bad_ff,
                                              out_ff != cmd_ff};
               `ADDR_OUTPUT:  s_rdata_out <= {{16{out_ff[15]}}, out_ff};
               default: begin
                  if (s_araddr_in >= `ADDR_LIN_BASE &&
                      s_araddr_in < `ADDR_LIN_BASE + 8'(4 * NL)) begin
                     s_rdata_out <= {16'h0, lin_ff[4'((s_araddr_in
                                    - `ADDR_LIN_BASE) >> 2)]};
                  end else begin
                     s_rresp_out <= `RESP_SLVERR;
                  end
               end
            endcase
         end
      end
   end

   assign tick = (tick_ff == 10'(`SAMPLE_CYC - 1));
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) tick_ff <= 10'h000;
      else tick_ff <= tick ? 10'h000 : tick_ff + 10'h001; // see RQ16
   end

   // Command chain, evaluated combinationally every cycle; cmd_ff takes its result once per sample.
   logic signed [15:0] s_pol, s_thr, s_go, s_lin;
   logic signed [31:0] t32, seg;
   logic [31:0]        thr_lvl;
   logic [3:0]         k;
   always_comb begin
      t32 = 32'sd0;
      seg = 32'sd0;
      k = 4'h0;
      s_pol = to_cmd(cmd_raw_in, stype); // see RQ1
      if (ctrl_ff[`CTRL_POL_BIT]) s_pol = -s_pol; // see RQ4
      thr_lvl = (32'd32767 * {24'h0, thresh_ff}) / 32'd100; // see RQ5
      s_thr = ({16'h0, s_pol < 0 ? 16'(-s_pol) : s_pol} <= thr_lvl)
              ? 16'sd0 : s_pol; // see RQ6 // see RQ7
      t32 = (32'(s_thr) * $signed({16'h0, gain_ff})) >>> 8; // see RQ8
      if (s_thr > 0) t32 = t32 + {16'h0, offset_ff}; // see RQ9
      else if (s_thr < 0) t32 = t32 - {16'h0, offset_ff};
      s_go = sat(t32);
      s_lin = s_go;
      if (ctrl_ff[`CTRL_LINEN_BIT] && !lin_bad_ff) begin // see RQ10
         seg = 32'(s_go) + 32'sd32767;
         k = 4'(seg / 32'sd8192);
         if (k > 4'(NL - 2)) k = 4'(NL - 2);
         seg = seg - 32'sd8192 * 32'(k);
         s_lin = sat(32'(lin_ff[k]) + (32'(lin_ff[k+1]) - 32'(lin_ff[k]))
                     * seg / 32'sd8192);
      end
   end

   // Step per sample is full scale over ramp time; the remainder carries
   // in an accumulator so slope stays constant for any step size.
   logic [1:0]  rsel;
   logic [31:0] nxt_acc;
   logic        up;
   always_comb begin
      up = cmd_ff > out_ff;
      // Range above zero uses ramps 0/1, below zero 2/3. see RQ14
      if (out_ff > 0 || (out_ff == 0 && up)) rsel = up ? 2'd0 : 2'd1;
      else rsel = up ? 2'd3 : 2'd2; // see RQ15
      nxt_acc = acc_ff + 32'd32767;
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cmd_ff <= 16'sh0000;
         out_ff <= 16'sh0000;
         acc_ff <= 32'h0000_0000;
      end else if (tick) begin
         cmd_ff <= s_lin;
         if (ramp_ff[rsel] == 16'h0000 || cmd_ff == out_ff) begin
            out_ff <= cmd_ff; // see RQ11
            acc_ff <= 32'h0000_0000;
         end else begin // see RQ12
            automatic logic [31:0] st = nxt_acc / {16'h0, ramp_ff[rsel]};
            automatic logic signed [31:0] d = 32'(cmd_ff) - 32'(out_ff);
            acc_ff <= nxt_acc - st * {16'h0, ramp_ff[rsel]};
            if (up) out_ff <= (32'(st) >= d) ? cmd_ff : 16'(out_ff + st);
            else out_ff <= (32'(st) >= -d) ? cmd_ff : 16'(out_ff - st);
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         coil_out   <= '0;
         sample_out <= 1'b0;
      end else begin
         sample_out <= tick;
         coil_out.coil_a <= out_ff > 0; // see RQ3
         coil_out.coil_b <= out_ff < 0;
         coil_out.demand <= out_ff < 0 ? 16'(-out_ff) : out_ff;
      end
   end
endmodule : command_signal_conditioning

// [verification/cmd_cond_checker.sv]
`timescale 1ns/1ps
`include "cmd_cond_defs.svh"
module cmd_cond_checker
   import cmd_cond_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // Bus handshakes.
   input  wire logic        s_awvalid_in,
   input  wire logic        s_awready_out,
   input  wire logic        s_wvalid_in,
   input  wire logic        s_wready_out,
   input  wire logic        s_bvalid_out,
   input  wire logic        s_bready_in,
   input  wire logic        s_arvalid_in,
   input  wire logic        s_arready_out,
   input  wire logic        s_rvalid_out,
   input  wire logic        s_rready_in,
   input  wire logic [31:0] s_rdata_out,
   // Coil side.
   input  wire coil_out_t   coil_out,
   input  wire logic        sample_out
);
   logic [10:0] gap_ff;
   logic        seen_ff;
   // The first pulse after reset has no predecessor, so it is not judged.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         gap_ff  <= 11'h000;
         seen_ff <= 1'b0;
      end else begin
         gap_ff  <= sample_out ? 11'h000 : gap_ff + 11'h001;
         seen_ff <= seen_ff | sample_out;
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   bresp_time_a: assert property (s_awvalid_in && s_awready_out &&
      s_wvalid_in && s_wready_out && !s_bvalid_out |-> ##2 s_bvalid_out)
      else $error("write answer late");
   bresp_hold_a: assert property (s_bvalid_out && !s_bready_in |=>
      s_bvalid_out) else $error("write answer dropped");
   rresp_time_a: assert property (s_arvalid_in && s_arready_out |=>
      s_rvalid_out) else $error("read answer late");
   rresp_hold_a: assert property (s_rvalid_out && !s_rready_in |=>
      s_rvalid_out && $stable(s_rdata_out)) else $error("read answer moved");
   coil_excl_a: assert property (
      !(coil_out.coil_a && coil_out.coil_b)) else $error("both coils on");
   coil_mag_a: assert property ((coil_out.demand == 16'h0000) ==
      !(coil_out.coil_a || coil_out.coil_b))
      else $error("coil and demand differ");
   sat_a: assert property (coil_out.demand <= 16'h7fff)
      else $error("demand above full scale");
   coil_hold_a: assert property (!sample_out |=> $stable(coil_out))
      else $error("coil moved between samples");
   period_a: assert property (sample_out && seen_ff |->
      gap_ff == `SAMPLE_CYC - 1) else $error("sample period wrong");
   pulse_one_a: assert property (sample_out |=> !sample_out)
      else $error("sample pulse too long");
endmodule : cmd_cond_checker
bind command_signal_conditioning cmd_cond_checker chk_u (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .s_awvalid_in(s_awvalid_in), .s_wvalid_in(s_wvalid_in),
   .s_awready_out(s_awready_out), .s_wready_out(s_wready_out),
   .s_bvalid_out(s_bvalid_out), .s_bready_in(s_bready_in),
   .s_arvalid_in(s_arvalid_in), .s_arready_out(s_arready_out),
   .s_rvalid_out(s_rvalid_out), .s_rready_in(s_rready_in),
   .s_rdata_out(s_rdata_out), .coil_out(coil_out), .sample_out(sample_out));

// [verification/cmd_source.sv]
`timescale 1ns/1ps
module cmd_source (
   // Clock.
   input  wire logic        clk_sys_in,
   // Level asked for by the bench, offset binary.
   input  wire logic [15:0] level_in,
   // Converter code toward the block.
   output logic      [15:0] raw_out
);
   // Like a real converter the code moves only at an edge, never between.
   always_ff @(posedge clk_sys_in) begin
      raw_out <= level_in;
   end
endmodule : cmd_source

// [verification/tb_command_signal_conditioning.sv]
`timescale 1ns/1ps
`include "cmd_cond_defs.svh"
`define CHK(n, e, g) check(n, e, g);
module tb_command_signal_conditioning
   import cmd_cond_pkg::*;
;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [15:0] level = 16'h8000;
   logic [15:0] raw;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, sample;
   logic [1:0]  bresp, rresp;
   coil_out_t   coil;
   int          mismatches = 0;
   int          tests_run = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   cmd_source src_u (.clk_sys_in(clk_sys_in), .level_in(level),
      .raw_out(raw));
   command_signal_conditioning dut_u (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_raw_in(raw),
      .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready),
      .s_wdata_in(wdata), .s_wstrb_in(4'hf), .s_wvalid_in(wvalid),
      .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid),
      .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
      .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp),
      .s_rvalid_out(rvalid), .s_rready_in(rready), .coil_out(coil),
      .sample_out(sample));
   task automatic conclude();
      $display("Compared %0d, mismatched %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic hung();
      mismatches++;
      $display("BAD wait expected done seen timeout");
      conclude();
   endtask : hung
   task automatic reset_dut();
      rst_n_in <= 1'b0;
      // Every scenario starts from a centred command, whatever came before.
      level <= 16'h8000;
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
   endtask : reset_dut
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      int n;
      @(posedge clk_sys_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) hung();
      `CHK("bresp", er, bresp)
   endtask : wr
   task automatic rd(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys_in);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      if (n == 50) hung();
      `CHK("rresp", er, rresp)
   endtask : rd
   // Counting pulses, not cycles, keeps the bench free of the tick phase.
   task automatic samples(int k);
      int n;
      int c;
      c = 0;
      for (n = 0; n < 1100 * k && c < k; n++) begin
         @(posedge clk_sys_in);
         if (sample) c++;
      end
      // The coil word follows the pulse by one edge.
      @(posedge clk_sys_in);
      if (c < k) hung();
   endtask : samples
   task automatic regs_check();
      logic [31:0] d;
      reset_dut();
      rd(`ADDR_CTRL, `RESP_OKAY, d);
      `CHK("ctrl reset", `CTRL_RESET, d)
      rd(`ADDR_GAIN, `RESP_OKAY, d);
      `CHK("gain reset", `GAIN_RESET, d)
      rd(8'h3c, `RESP_SLVERR, d);
      wr(8'h3c, 32'h1, `RESP_SLVERR);
      wr(`ADDR_THRESH, 32'hc8, `RESP_OKAY);
      rd(`ADDR_THRESH, `RESP_OKAY, d);
      `CHK("thresh clip", 32'h64, d)
   endtask : regs_check
   task automatic type_check();
      int t;
      reset_dut();
      wr(`ADDR_GAIN, 32'h200, `RESP_OKAY);
      level <= 16'hffff;
      for (t = 0; t < 6; t++) begin
         wr(`ADDR_CTRL, t, `RESP_OKAY);
         samples(2);
         `CHK("coil type", {2'b10, 16'h7fff}, coil)
      end
      level <= 16'h4000;
      wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
      samples(2);
      `CHK("coil unipolar", {2'b10, 16'h4000}, coil)
   endtask : type_check
   task automatic polarity_check();
      reset_dut();
      wr(`ADDR_GAIN, 32'h200, `RESP_OKAY);
      level <= 16'hc000;
      samples(2);
      `CHK("coil pos", {2'b10, 16'h7fff}, coil)
      level <= 16'h4000;
      samples(2);
      `CHK("coil neg", {2'b01, 16'h7fff}, coil)
      wr(`ADDR_CTRL, 32'h10, `RESP_OKAY);
      samples(2);
      `CHK("coil swap", {2'b10, 16'h7fff}, coil)
      level <= 16'h8000;
      samples(2);
      `CHK("coil idle", 18'h0, coil)
   endtask : polarity_check
   task automatic threshold_check();
      reset_dut();
      wr(`ADDR_THRESH, 32'd50, `RESP_OKAY);
      level <= 16'he000;
      samples(2);
      `CHK("above thresh", {2'b10, 16'h6000}, coil)
      level <= 16'ha000;
      samples(2);
      `CHK("below thresh", 18'h0, coil)
   endtask : threshold_check
   task automatic offset_check();
      reset_dut();
      wr(`ADDR_OFFSET, 32'h100, `RESP_OKAY);
      samples(2);
      `CHK("offset zero", 18'h0, coil)
      level <= 16'h8001;
      samples(2);
      `CHK("offset pos", {2'b10, 16'h0101}, coil)
      level <= 16'h7fff;
      samples(2);
      `CHK("offset neg", {2'b01, 16'h0101}, coil)
   endtask : offset_check
   task automatic curve_check();
      logic [31:0] d;
      reset_dut();
      wr(`ADDR_CTRL, 32'h20, `RESP_OKAY);
      rd(`ADDR_STATUS, `RESP_OKAY, d);
      `CHK("curve taken", 1'b0, d[1])
      wr(`ADDR_LIN_BASE + 8'h10, 32'h7000, `RESP_OKAY);
      rd(`ADDR_STATUS, `RESP_OKAY, d);
      `CHK("curve refused", 1'b1, d[1])
      level <= 16'he000;
      samples(2);
      `CHK("curve bypass", {2'b10, 16'h6000}, coil)
   endtask : curve_check
   task automatic ramp_check();
      logic [31:0] d;
      logic        mid;
      reset_dut();
      wr(`ADDR_RAMP_PU, 32'd10, `RESP_OKAY);
      level <= 16'hffff;
      samples(5);
      rd(`ADDR_OUTPUT, `RESP_OKAY, d);
      mid = $signed(d) > 8000 && $signed(d) < 25000;
      `CHK("ramp mid", 1'b1, mid)
      samples(8);
      `CHK("ramp end", {2'b10, 16'h7fff}, coil)
      wr(`ADDR_RAMP_ALL, 32'd4, `RESP_OKAY);
      level <= 16'h0000;
      samples(2);
      `CHK("ramp down", 2'b10, {coil.coil_a, coil.coil_b})
      samples(8);
      `CHK("ramp cross", {2'b01, 16'h7fff}, coil)
   endtask : ramp_check
   initial begin
      regs_check();
      type_check();
      polarity_check();
      threshold_check();
      offset_check();
      curve_check();
      ramp_check();
      conclude();
   end
endmodule : tb_command_signal_conditioning
